// ---- gpc_lane.sv ----
// gpc_lane: one pin of the port - input synchroniser, sampling, event
// detection and registered pad controls
// assumes ctrl_in, drive_en_in and drive_lvl_in come from the system clock
`timescale 1ns/10ps
module gpc_lane
  import gpc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       pin_in,
  input  wire logic [7:0] ctrl_in,
  input  wire logic       drive_en_in,
  input  wire logic       drive_lvl_in,
  output logic            sampled_out,
  output logic            event_out,
  output logic            pin_out,
  output logic            oe_out,
  output logic            pull_out
);
  logic       meta_q;
  logic       sync_q;
  logic       samp_q;
  logic       flip;
  logic       buf_on;
  logic       lvl;
  gpc_sense_t sense;

  assign flip   = ctrl_in[POS_FLIP];
  assign sense  = gpc_sense_t'(ctrl_in[POS_SENSE +: 3]);
  assign buf_on = (sense != SNS_BUF_OFF);
  assign lvl    = sync_q ^ flip;
  assign sampled_out = samp_q;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // a frozen bit may look like an edge once the buffer is switched back on
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      samp_q <= 1'b0;
    end else if (buf_on) begin
      samp_q <= lvl;
    end
  end

  always_comb begin
    event_out = 1'b0;
    case (sense)
      SNS_ANY_EDGE: event_out = lvl ^ samp_q;
      SNS_RISE:     event_out = lvl & ~samp_q;
      SNS_FALL:     event_out = ~lvl & samp_q;
      SNS_LOW:      event_out = ~lvl;
      default:      event_out = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_out  <= 1'b0;
      oe_out   <= 1'b0;
      pull_out <= 1'b0;
    end else begin
      pin_out  <= drive_lvl_in ^ flip;
      oe_out   <= drive_en_in;
      pull_out <= ctrl_in[POS_PULL] & ~drive_en_in;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_in_flip;
    (buf_on && $stable(ctrl_in))[*3] |-> samp_q == ($past(pin_in, 3) ^ flip);
  endproperty
  a_in_flip: assert property (p_in_flip)
    else $error("sampled bit not pin level xor flip");

  property p_buf_hold;
    !buf_on |=> samp_q == $past(samp_q);
  endproperty
  a_buf_hold: assert property (p_buf_hold)
    else $error("sampled bit moved with buffer off");

  property p_low_retrig;
    (sense == SNS_LOW && !flip && !pin_in && $stable(ctrl_in))[*3] |-> event_out;
  endproperty
  a_low_retrig: assert property (p_low_retrig)
    else $error("low level did not retrigger");

endmodule

// ---- gpc_pin_model.sv ----
// gpc_pin_model: package pins of one eight-pin port, as seen from the board
// assumes pad controls from gpc_top; the board drives pins where ext_en_in is set and the port output enable is clear
`timescale 1ns/10ps
module gpc_pin_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] drv_lvl_in,
  input  wire logic [7:0] drv_oe_in,
  input  wire logic [7:0] pull_in,
  input  wire logic [7:0] ext_en_in,
  input  wire logic [7:0] ext_lvl_in,
  output logic      [7:0] pin_out
);
  logic [7:0] tog_q;

  // a floating pin must not look stable, so it wanders every cycle
  always @(posedge clk_in) begin
    tog_q <= ~tog_q;
  end

  initial tog_q = 8'h5a;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drv_oe_in[i]) begin
        pin_out[i] = drv_lvl_in[i];
      end else if (ext_en_in[i]) begin
        pin_out[i] = ext_lvl_in[i];
      end else if (pull_in[i]) begin
        pin_out[i] = 1'b1;
      end else begin
        pin_out[i] = tog_q[i];
      end
    end
  end
endmodule

// ---- gpc_pkg.sv ----
// gpc_pkg: register indices, field positions, reset values and sense codes
// of the eight-pin port; byte address on the bus is four times the index
package gpc_pkg;

  localparam int NPIN = 8;

  localparam logic [5:0] IDX_DRIVE_EN   = 6'h00;
  localparam logic [5:0] IDX_DRIVE_LVL  = 6'h01;
  localparam logic [5:0] IDX_SAMPLED    = 6'h02;
  localparam logic [5:0] IDX_EVENTS     = 6'h03;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h04;
  localparam logic [5:0] IDX_SHARED_PAT = 6'h0b;
  localparam logic [5:0] IDX_BULK_SET   = 6'h0d;
  localparam logic [5:0] IDX_BULK_CLR   = 6'h0e;
  localparam logic [5:0] IDX_LANE_BASE  = 6'h10;
  localparam logic [5:0] IDX_LANE_LAST  = 6'h17;

  localparam int POS_FLIP  = 7;
  localparam int POS_PULL  = 3;
  localparam int POS_SENSE = 0;

  // bits 6:4 of a lane setup are not implemented and read as zero
  localparam logic [7:0]  CTRL_IMPL = 8'h8f;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;

  typedef enum logic [2:0] {
    SNS_OFF_BUF_ON = 3'h0,
    SNS_ANY_EDGE   = 3'h1,
    SNS_RISE       = 3'h2,
    SNS_FALL       = 3'h3,
    SNS_BUF_OFF    = 3'h4,
    SNS_LOW        = 3'h5
  } gpc_sense_t;

endpackage

// ---- gpc_top.sv ----
// gpc_top: eight-pin port with apb register slave, bulk lane setup,
// fast alias registers, event flags and a masked interrupt
// assumes a single 50 MHz clock; pins are asynchronous to it
//
// Contract
// - bulk set mask bit n ORs the shared pattern into lane setup n
// - bulk clear mask bit n clears pattern bits in lane setup n
// - zero mask bits leave their lane setup untouched
// - reads of the bulk set and clear masks return zero
// - one bulk write updates all selected lanes in one cycle
// - polarity flip inverts both sampled input and driven output
// - weak pull-up acts only while the pin is input-only
// - codes 0 to 3 keep buffer on: none, any edge, rise, fall
// - code 4 turns buffer and events off; sampled bit freezes
// - code 5 senses low level and retriggers while pin stays low
// - alias registers at 0x00 to 0x03 act as the port registers
// - drive enable one drives the pin, zero makes it input-only
// - drive enable does not touch the input buffer
// - drive level sets the pin level while drive enable is set
// - writing one to a sampled bit toggles the drive level bit
// - event flag sets on a sense match, clears on write of one
// - shared pattern is mirrored across all port instances
`timescale 1ns/10ps
module gpc_top
  import gpc_pkg::*;
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic [7:0]  PIN_IN,
  output logic      [7:0]  PIN_OUT,
  output logic      [7:0]  PIN_OE_OUT,
  output logic      [7:0]  PULLUP_EN_OUT,
  input  wire logic [7:0]  SHARED_PAT_IN,
  input  wire logic        SHARED_PAT_LOAD_IN,
  output logic      [7:0]  SHARED_PAT_OUT,
  output logic             SHARED_PAT_WR_OUT,
  output logic             IRQ_OUT
);
  logic [7:0]  drive_en_q;
  logic [7:0]  drive_lvl_q;
  logic [7:0]  flags_q;
  logic [7:0]  mask_q;
  logic [7:0]  pat_q;
  logic [7:0]  ctrl_q [NPIN];
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        irq_q;
  logic        pat_wr_q;

  logic [5:0]  idx;
  logic [2:0]  lane_sel;
  logic        lane_hit;
  logic        setup;
  logic        acc;
  logic        wr;
  logic        mapped;
  logic [7:0]  wb;
  logic [7:0]  rd_byte;
  logic [7:0]  samp_v;
  logic [7:0]  ev_v;
  logic [7:0]  clr_v;

  assign idx      = PADDR_IN[7:2];
  assign lane_sel = idx[2:0];
  assign lane_hit = (idx >= IDX_LANE_BASE) && (idx <= IDX_LANE_LAST);
  assign setup    = PSEL_IN && !PENABLE_IN;
  assign acc      = PSEL_IN && PENABLE_IN && pready_q;
  // only byte lane 0 carries register data
  assign wr       = acc && PWRITE_IN && PSTRB_IN[0] && mapped;
  assign wb       = PWDATA_IN[7:0];

  assign PRDATA_OUT        = prdata_q;
  assign PREADY_OUT        = pready_q;
  assign PSLVERR_OUT       = pslverr_q;
  assign IRQ_OUT           = irq_q;
  assign SHARED_PAT_OUT    = pat_q;
  assign SHARED_PAT_WR_OUT = pat_wr_q;

  always_comb begin
    mapped = lane_hit;
    case (idx)
      IDX_DRIVE_EN,
      IDX_DRIVE_LVL,
      IDX_SAMPLED,
      IDX_EVENTS,
      IDX_IRQ_MASK,
      IDX_SHARED_PAT,
      IDX_BULK_SET,
      IDX_BULK_CLR: mapped = 1'b1;
      default:      mapped = lane_hit;
    endcase
  end

  always_comb begin
    rd_byte = RST_BYTE;
    case (idx)
      IDX_DRIVE_EN:   rd_byte = drive_en_q;
      IDX_DRIVE_LVL:  rd_byte = drive_lvl_q;
      IDX_SAMPLED:    rd_byte = samp_v;
      IDX_EVENTS:     rd_byte = flags_q;
      IDX_IRQ_MASK:   rd_byte = mask_q;
      IDX_SHARED_PAT: rd_byte = pat_q;
      IDX_BULK_SET:   rd_byte = RST_BYTE;
      IDX_BULK_CLR:   rd_byte = RST_BYTE;
      default: begin
        if (lane_hit) begin
          rd_byte = ctrl_q[lane_sel];
        end
      end
    endcase
  end

  // zero wait states: read data is taken in the setup cycle
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      prdata_q  <= RST_WORD;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      if (setup) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      drive_en_q <= RST_BYTE;
    end else if (wr && idx == IDX_DRIVE_EN) begin
      drive_en_q <= wb;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      drive_lvl_q <= RST_BYTE;
    end else if (wr && idx == IDX_DRIVE_LVL) begin
      drive_lvl_q <= wb;
    end else if (wr && idx == IDX_SAMPLED) begin
      drive_lvl_q <= drive_lvl_q ^ wb;
    end
  end

  assign clr_v = (wr && idx == IDX_EVENTS) ? wb : RST_BYTE;

  // a new event beats a clear landing in the same cycle
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      flags_q <= RST_BYTE;
    end else begin
      flags_q <= (flags_q & ~clr_v) | ev_v;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      mask_q <= RST_BYTE;
    end else if (wr && idx == IDX_IRQ_MASK) begin
      mask_q <= wb;
    end
  end

  // irq lags the flag by one cycle so that it comes from a flop
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_q & mask_q);
    end
  end

  // a local write wins over a mirrored load from another port
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pat_q    <= RST_BYTE;
      pat_wr_q <= 1'b0;
    end else begin
      pat_wr_q <= wr && idx == IDX_SHARED_PAT;
      if (wr && idx == IDX_SHARED_PAT) begin
        pat_q <= wb & CTRL_IMPL;
      end else if (SHARED_PAT_LOAD_IN) begin
        pat_q <= SHARED_PAT_IN & CTRL_IMPL;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      for (int i = 0; i < NPIN; i++) begin
        ctrl_q[i] <= RST_BYTE;
      end
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        if (wr && lane_hit && lane_sel == 3'(i)) begin
          ctrl_q[i] <= wb & CTRL_IMPL;
        end else if (wr && idx == IDX_BULK_SET && wb[i]) begin
          ctrl_q[i] <= ctrl_q[i] | pat_q;
        end else if (wr && idx == IDX_BULK_CLR && wb[i]) begin
          ctrl_q[i] <= ctrl_q[i] & ~pat_q;
        end
      end
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!ARST_N_IN);

  sequence s_wr(logic [5:0] ix);
    PSEL_IN && PENABLE_IN && pready_q && PWRITE_IN && PSTRB_IN[0] && idx == ix;
  endsequence

  sequence s_rd(logic [5:0] ix);
    PSEL_IN && PENABLE_IN && pready_q && !PWRITE_IN && idx == ix;
  endsequence

  for (genvar k = 0; k < NPIN; k++) begin : g_lane
    gpc_lane u_lane (
      .clk_in       (CLK_SYS_IN),
      .arst_n_in    (ARST_N_IN),
      .pin_in       (PIN_IN[k]),
      .ctrl_in      (ctrl_q[k]),
      .drive_en_in  (drive_en_q[k]),
      .drive_lvl_in (drive_lvl_q[k]),
      .sampled_out  (samp_v[k]),
      .event_out    (ev_v[k]),
      .pin_out      (PIN_OUT[k]),
      .oe_out       (PIN_OE_OUT[k]),
      .pull_out     (PULLUP_EN_OUT[k])
    );

    property p_bulk_set;
      s_wr(IDX_BULK_SET) |=> ctrl_q[k] == ($past(PWDATA_IN[k]) ?
        ($past(ctrl_q[k]) | $past(pat_q)) : $past(ctrl_q[k]));
    endproperty
    a_bulk_set: assert property (p_bulk_set)
      else $error("bulk set gave wrong lane setup");

    property p_bulk_clr;
      s_wr(IDX_BULK_CLR) |=> ctrl_q[k] == ($past(PWDATA_IN[k]) ?
        ($past(ctrl_q[k]) & ~$past(pat_q)) : $past(ctrl_q[k]));
    endproperty
    a_bulk_clr: assert property (p_bulk_clr)
      else $error("bulk clear gave wrong lane setup");

    property p_pad_level;
      PIN_OUT[k] == ($past(drive_lvl_q[k]) ^ $past(ctrl_q[k][POS_FLIP]));
    endproperty
    a_pad_level: assert property (p_pad_level)
      else $error("pad level not drive level xor flip");
  end

  property p_mask_read_zero;
    (s_rd(IDX_BULK_SET) or s_rd(IDX_BULK_CLR)) |-> PRDATA_OUT == RST_WORD;
  endproperty
  a_mask_read_zero: assert property (p_mask_read_zero)
    else $error("bulk mask read not zero");

  property p_alias_read;
    s_rd(IDX_DRIVE_EN) |-> PRDATA_OUT[7:0] == $past(drive_en_q);
  endproperty
  a_alias_read: assert property (p_alias_read)
    else $error("alias drive enable read mismatch");

  property p_oe_follow;
    s_wr(IDX_DRIVE_EN) |=> ##1 PIN_OE_OUT == $past(PWDATA_IN[7:0], 2);
  endproperty
  a_oe_follow: assert property (p_oe_follow)
    else $error("output enable did not follow write");

  property p_pull_input_only;
    (PULLUP_EN_OUT & PIN_OE_OUT) == RST_BYTE;
  endproperty
  a_pull_input_only: assert property (p_pull_input_only)
    else $error("pull-up on a driven pin");

  property p_toggle;
    s_wr(IDX_SAMPLED) |=> (drive_lvl_q ^ $past(drive_lvl_q)) == $past(PWDATA_IN[7:0]);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("sampled write did not toggle drive level");

  property p_set_wins;
    (s_wr(IDX_EVENTS) ##0 ev_v != RST_BYTE) |=> (flags_q & $past(ev_v)) == $past(ev_v);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost under clear");

  property p_irq;
    (|(flags_q & mask_q)) ##1 (|(flags_q & mask_q)) |-> IRQ_OUT;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt low with unmasked flag");

  // ready must be a single-cycle pulse or a master would see two transfers
  sequence s_ready_pulse;
    PREADY_OUT ##1 !PREADY_OUT;
  endsequence

  property p_ready;
    setup |=> s_ready_pulse;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready not a one-cycle pulse after setup");

  property p_slverr;
    setup |=> PSLVERR_OUT == !$past(mapped);
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("error flag does not match the address map");

  property p_pat_write;
    s_wr(IDX_SHARED_PAT) |=> SHARED_PAT_WR_OUT &&
      SHARED_PAT_OUT == ($past(PWDATA_IN[7:0]) & CTRL_IMPL);
  endproperty
  a_pat_write: assert property (p_pat_write)
    else $error("local pattern write not published");

  property p_pat_load;
    SHARED_PAT_LOAD_IN && !(wr && idx == IDX_SHARED_PAT) |=>
      SHARED_PAT_OUT == ($past(SHARED_PAT_IN) & CTRL_IMPL);
  endproperty
  a_pat_load: assert property (p_pat_load)
    else $error("mirrored pattern not loaded");

  property p_flag_clear;
    s_wr(IDX_EVENTS) |=> (flags_q & $past(PWDATA_IN[7:0]) & ~$past(ev_v)) == RST_BYTE;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("event flag survived a clear without a new event");

  property p_drive_lvl;
    s_wr(IDX_DRIVE_LVL) |=> drive_lvl_q == $past(PWDATA_IN[7:0]);
  endproperty
  a_drive_lvl: assert property (p_drive_lvl)
    else $error("drive level write not stored");

endmodule

// ---- gpio_pin_config_and_alias_bench.sv ----
// gpio_pin_config_and_alias_bench: register and pin tests of the port
// assumes an apb slave that adds fewer than 50 wait states and the pin model on the pad side
`timescale 1ns/10ps
module gpio_pin_config_and_alias_bench;
  import gpc_pkg::*;
  logic        clk_sys, arst_n, psel, penable, pwrite, pat_load, er;
  logic [7:0]  paddr, pin_in, pin_out, pin_oe, pull_en, pat_in, pat_out, ext_lvl, ext_en;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, pat_wr, irq;
  int          error_cnt, check_count;
  logic [7:0]  regs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h2c, 8'h34, 8'h38};
  logic [7:0]  cfg [8] = '{8'h08, 8'h87, 8'h06, 8'h04, 8'h0a, 8'h03, 8'h01, 8'h05};
  logic [7:0]  exp_l [8];

  gpc_top gpc_top_inst (
    .CLK_SYS_IN(clk_sys), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_OUT(pin_oe), .PULLUP_EN_OUT(pull_en),
    .SHARED_PAT_IN(pat_in), .SHARED_PAT_LOAD_IN(pat_load), .SHARED_PAT_OUT(pat_out),
    .SHARED_PAT_WR_OUT(pat_wr), .IRQ_OUT(irq));

  gpc_pin_model gpc_pin_model_inst (
    .clk_in(clk_sys), .drv_lvl_in(pin_out), .drv_oe_in(pin_oe), .pull_in(pull_en),
    .ext_en_in(ext_en), .ext_lvl_in(ext_lvl), .pin_out(pin_in));

  always #10 clk_sys = ~clk_sys;

  task automatic conclude();
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // the request is held until the edge at which pready is sampled high;
  // read data and error are taken at that same edge, then released
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 50) begin
      error_cnt++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, {24'h0, exp});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic lanes_chk();
    for (int i = 0; i < 8; i++) begin
      rd_chk(8'h40 + 8'(4 * i), exp_l[i]);
    end
  endtask

  initial begin
    clk_sys     = 1'b0;
    arst_n      = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    pstrb       = 4'hf;
    pat_in      = 8'h00;
    pat_load    = 1'b0;
    ext_en      = 8'hff;
    ext_lvl     = 8'h00;
    error_cnt   = 0;
    check_count = 0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    // the board holds every pin low at first, so the sampled bits settle at zero
    foreach (regs[i]) rd_chk(regs[i], RST_BYTE);
    foreach (exp_l[i]) exp_l[i] = RST_BYTE;
    lanes_chk();
    xfer(1'b0, 8'h3c, 32'h0);
    chk({rd[31:1], er}, 32'h1);
    // shared pattern: local write keeps only implemented bits, then a load from outside
    wr(8'h2c, 8'hff);
    wait_cyc(1);
    chk({31'h0, pat_wr}, 32'h1);
    rd_chk(8'h2c, 8'h8f);
    @(posedge clk_sys);
    pat_in   <= 8'h0a;
    pat_load <= 1'b1;
    @(posedge clk_sys);
    pat_load <= 1'b0;
    wait_cyc(2);
    chk({24'h0, pat_out}, 32'h0a);
    chk({31'h0, pat_wr}, 32'h0);
    rd_chk(8'h2c, 8'h0a);
    // bulk set and clear against a lane that already holds a bit
    wr(8'h40, 8'h80);
    wr(8'h34, 8'h05);
    exp_l[0] = 8'h8a;
    exp_l[2] = 8'h0a;
    lanes_chk();
    rd_chk(8'h34, 8'h00);
    wr(8'h2c, 8'h88);
    wr(8'h38, 8'h01);
    rd_chk(8'h38, 8'h00);
    exp_l[0] = 8'h02;
    lanes_chk();
    // pins 0..3 driven by the port, 4..7 by the board; the board lets go
    // of 0..3 only once the port drives them, so they never float
    @(posedge clk_sys);
    ext_lvl <= 8'hf0;
    wr(8'h00, 8'h0f);
    foreach (cfg[i]) wr(8'h40 + 8'(4 * i), cfg[i]);
    ext_en <= 8'hf0;
    wr(8'h04, 8'h05);
    wait_cyc(8);
    chk({24'h0, pin_oe}, 32'h0f);
    chk({24'h0, pin_out}, 32'h07);
    chk({24'h0, pull_en}, 32'h10);
    rd_chk(8'h08, 8'hf5);
    wr(8'h04, 8'h0d);
    wait_cyc(8);
    chk({24'h0, pin_out}, 32'h0f);
    rd_chk(8'h08, 8'hf5);
    wr(8'h08, 8'h03);
    rd_chk(8'h04, 8'h0e);
    wait_cyc(8);
    rd_chk(8'h08, 8'hf6);
    pstrb <= 4'h0;
    wr(8'h00, 8'hff);
    pstrb <= 4'hf;
    rd_chk(8'h00, 8'h0f);
    // events: output pin toggles above on codes 0, 4, 6, 7 must leave no flag
    rd_chk(8'h0c, 8'h00);
    wr(8'h0c, 8'hff);
    rd_chk(8'h0c, 8'h00);
    @(posedge clk_sys);
    ext_lvl <= 8'h00;
    wait_cyc(8);
    rd_chk(8'h0c, 8'he0);
    chk({31'h0, irq}, 32'h0);
    wr(8'h10, 8'h20);
    wait_cyc(3);
    chk({31'h0, irq}, 32'h1);
    wr(8'h0c, 8'h60);
    rd_chk(8'h0c, 8'h80);
    wait_cyc(3);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk_sys);
    ext_lvl <= 8'hf0;
    wait_cyc(8);
    rd_chk(8'h0c, 8'hd0);
    wr(8'h0c, 8'hff);
    rd_chk(8'h0c, 8'h00);
    conclude();
  end
endmodule
